// [rtl/pintc_pkg.sv]
// Package of the interrupt controller: offsets, fields, reset values
// Assumes a 32-bit APB slave with byte addresses; registers are 8 bits
package pintc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_MAIN = 8'h00;
   localparam logic [7:0] OFS_EDGE = 8'h04;
   localparam logic [7:0] OFS_EXT = 8'h08;
   localparam logic [7:0] OFS_PFLAG = 8'h0C;
   localparam logic [7:0] OFS_PEN = 8'h10;
   localparam logic [7:0] OFS_PPRIO = 8'h14;
   localparam logic [7:0] OFS_CHG_EN = 8'h18;
   localparam logic [7:0] OFS_PU_EN = 8'h1C;
   localparam logic [7:0] OFS_CFG = 8'h20;
   localparam logic [7:0] OFS_STAT = 8'h24;
   // Values after reset
   localparam logic [7:0] RST_MAIN = 8'h00;
   localparam logic [7:0] RST_EDGE = 8'hF5;
   localparam logic [7:0] RST_EXT = 8'hC0;
   localparam logic [7:0] RST_PFLAG = 8'h00;
   localparam logic [7:0] RST_PEN = 8'h00;
   localparam logic [7:0] RST_PPRIO = 8'hFF;
   localparam logic [7:0] RST_CHG_EN = 8'h00;
   localparam logic [7:0] RST_PU_EN = 8'h00;
   // Writable bit masks; the rest read as zero or are read-only
   localparam logic [7:0] WM_EDGE = 8'hF5;
   localparam logic [7:0] WM_EXT = 8'hDB;
   localparam logic [7:0] WM_PFLAG = 8'hCF;
   localparam logic [7:0] WM_CHG = 8'hF0;
   // Main register fields
   localparam int B_GIE = 7;
   localparam int B_PEIE = 6;
   localparam int B_T0EN = 5;
   localparam int B_I0EN = 4;
   localparam int B_RBEN = 3;
   localparam int B_T0F = 2;
   localparam int B_I0F = 1;
   localparam int B_RBF = 0;
   // Edge and priority register fields
   localparam int B_PUDIS = 7;
   localparam int B_EDGE0 = 6;
   localparam int B_T0P = 2;
   localparam int B_RBP = 0;
   // External pins register fields
   localparam int B_I2P = 7;
   localparam int B_I1P = 6;
   localparam int B_I2EN = 4;
   localparam int B_I1EN = 3;
   localparam int B_I2F = 1;
   localparam int B_I1F = 0;
   // Peripheral flag fields
   localparam int B_PSP = 7;
   localparam int B_RX = 5;
   localparam int B_TX = 4;
   localparam int B_CCP = 2;
   // Entry vectors
   localparam logic [15:0] VEC_HIGH = 16'h0008;
   localparam logic [15:0] VEC_LOW = 16'h0018;
   // Pin event to request latency in cycles
   localparam int LAT_MIN = 3;
   localparam int LAT_MAX = 4;
endpackage

// [rtl/pintc_top.sv]
// Interrupt controller of an 8-bit core: flags, enables, priorities
// Assumes an APB master, a core that acknowledges requests at an
// instruction boundary, and same-clock peripheral event pulses
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
module pintc_top import pintc_pkg::*; #(
   parameter bit HAS_SLAVE_PORT = 1'b1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] ext_pin,
   input wire logic [7:4] portb_pin,
   input wire logic portb_read,
   input wire logic [7:0] portb_is_input,
   output logic [7:0] pullup_on,
   input wire logic timer0_overflow,
   input wire logic [7:0] periph_event,
   input wire logic ccp1_pwm_mode,
   input wire logic rx_buffer_full,
   input wire logic tx_buffer_empty,
   input wire logic core_ack,
   input wire logic core_return_from_irq_instr,
   input wire logic [15:0] core_return_pc,
   output logic irq_req,
   output logic stack_push,
   output logic [15:0] stack_push_addr,
   output logic pc_load,
   output logic [15:0] pc_load_addr
);
   import pintc_pkg::*;

   logic [7:0] reg_main; // Enables and core flags
   logic [7:0] reg_edge; // Edge select, pull-up and priority
   logic [7:0] reg_ext; // External pins 1 and 2
   logic [7:0] reg_pflag; // Peripheral flags, stored part
   logic [7:0] reg_pen; // Peripheral enables
   logic [7:0] reg_pprio; // Peripheral priorities
   logic [7:0] reg_chg_en; // Per-pin change enables
   logic [7:0] reg_pu_en; // Per-pin pull-up enables
   logic prio_on; // Two-level priority mode
   logic hi_active; // High service in progress
   logic lo_active; // Low service in progress
   logic [2:0] sync1, sync2, sync3; // Pin synchronisers
   logic [7:4] pb1, pb2, pb3; // Port pin synchronisers
   logic [7:4] pb_latch; // Value seen at last port read
   logic [7:4] pb_changed; // Pins that changed since last read
   logic [2:0] ext_edge; // Qualified pin edges
   logic [2:0] ext_lvl; // Accepted pin levels
   logic [7:4] pb_lvl; // Accepted port levels
   logic [3:0] fill_sr; // Marks stages holding real samples
   logic lvl_ok; // Accepted levels are trustworthy
   logic [7:0] pflag_view; // Peripheral flags as read
   logic [7:0] rd_value; // Read mux
   logic wr_en; // Access-phase write
   logic mapped; // Address hits a register
   logic req_hi, req_lo; // Pending requests by level
   logic take_hi; // Entry level chosen at ack

   // Address decode shared by read mux and error answer
   function automatic logic is_ofs(input logic [11:0] a,
                                   input logic [7:0] o);
      is_ofs = (a == {4'h0, o});
   endfunction

   // Edge qualifier for one external pin
   function automatic logic edge_hit(input logic now, input logic old,
                                     input logic rising);
      edge_hit = rising ? (now & ~old) : (~now & old);
   endfunction

   // APB slave: zero wait states, error on unmapped address
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign mapped = is_ofs(paddr, OFS_MAIN) | is_ofs(paddr, OFS_EDGE)
      | is_ofs(paddr, OFS_EXT) | is_ofs(paddr, OFS_PFLAG)
      | is_ofs(paddr, OFS_PEN) | is_ofs(paddr, OFS_PPRIO)
      | is_ofs(paddr, OFS_CHG_EN) | is_ofs(paddr, OFS_PU_EN)
      | is_ofs(paddr, OFS_CFG) | is_ofs(paddr, OFS_STAT);
   assign pslverr = psel & penable & ~mapped;

   // Three-flop synchronisers for pins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         sync3 <= 3'h0;
         pb1 <= 4'h0;
         pb2 <= 4'h0;
         pb3 <= 4'h0;
      end else begin
         sync1 <= ext_pin;
         sync2 <= sync1;
         sync3 <= sync2;
         pb1 <= portb_pin;
         pb2 <= pb1;
         pb3 <= pb2;
      end
   end

   // Accepted levels: majority of stages two, three and the old level,
   // so a change counts once those stages agree; right after reset the
   // levels load silently, keeping a high pin from faking an edge
   // Fixed pin latency
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fill_sr <= 4'h0;
         ext_lvl <= 3'h0;
         pb_lvl <= 4'h0;
      end else begin
         fill_sr <= {fill_sr[2:0], 1'b1};
         if (!lvl_ok) begin
            ext_lvl <= sync3;
            pb_lvl <= pb3;
         end else begin
            ext_lvl <= (sync2 & sync3) | (ext_lvl & (sync2 | sync3));
            pb_lvl <= (pb2 & pb3) | (pb_lvl & (pb2 | pb3));
         end
      end
   end
   assign lvl_ok = fill_sr[3];

   // Edge detect per pin once stages two and three agree
   // Edge polarity select
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_edge
         assign ext_edge[gi] = lvl_ok & (sync2[gi] == sync3[gi])
            & edge_hit(sync3[gi], ext_lvl[gi], reg_edge[B_EDGE0 - gi]);
      end
   endgenerate

   // Port latch and change tracking, refreshed by a port read
   // Mismatch against last read
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pb_latch <= 4'h0;
         pb_changed <= 4'h0;
      end else if (portb_read) begin
         pb_latch <= pb_lvl;
         pb_changed <= 4'h0;
      end else begin
         pb_changed <= pb_changed | (pb_lvl ^ pb_latch);
      end
   end

   // Service state and entry level
   // Low is held off during high service
   always_comb begin
      logic [4:0] f, e, p;
      logic [7:0] pact;
      f = {reg_ext[B_I2F], reg_ext[B_I1F], reg_main[B_RBF],
           reg_main[B_I0F], reg_main[B_T0F]};
      e = {reg_ext[B_I2EN], reg_ext[B_I1EN],
           reg_main[B_RBEN] & |(pb_changed & reg_chg_en[7:4]),
           reg_main[B_I0EN], reg_main[B_T0EN]};
      p = {reg_ext[B_I2P], reg_ext[B_I1P], reg_edge[B_RBP], 1'b1,
           reg_edge[B_T0P]};
      pact = pflag_view & reg_pen;
      if (prio_on) begin
         req_hi = reg_main[B_GIE]
            & (|(f & e & p) | |(pact & reg_pprio));
         req_lo = reg_main[B_GIE] & reg_main[B_PEIE] & ~hi_active
            & (|(f & e & ~p) | |(pact & ~reg_pprio));
      end else begin
         req_hi = reg_main[B_GIE]
            & (|(f & e) | (reg_main[B_PEIE] & |pact));
         req_lo = 1'b0;
      end
   end
   assign irq_req = req_hi | req_lo;
   assign take_hi = req_hi;

   // Main register: software writes, hardware sets, entry and return
   // Main register layout
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_main <= RST_MAIN;
      end else begin
         logic [7:0] next_main;
         next_main = (wr_en && is_ofs(paddr, OFS_MAIN)) ?
            pwdata[7:0] : reg_main;
         if (core_return_from_irq_instr) begin
            if (!prio_on || hi_active) begin
               next_main[B_GIE] = 1'b1;
            end else begin
               next_main[B_PEIE] = 1'b1;
            end
         end
         if (core_ack && irq_req) begin
            if (!prio_on || take_hi) begin
               next_main[B_GIE] = 1'b0;
            end else begin
               next_main[B_PEIE] = 1'b0;
            end
         end
         next_main[B_T0F] = next_main[B_T0F] | timer0_overflow;
         next_main[B_I0F] = next_main[B_I0F] | ext_edge[0];
         next_main[B_RBF] = next_main[B_RBF] | |(pb_lvl ^ pb_latch);
         reg_main <= next_main;
      end
   end

   // Edge/priority and external pin registers
   // Pin 1 and 2 enables and flags
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_edge <= RST_EDGE;
         reg_ext <= RST_EXT;
      end else begin
         logic [7:0] next_ext;
         next_ext = (wr_en && is_ofs(paddr, OFS_EXT)) ?
            (pwdata[7:0] & WM_EXT) : reg_ext;
         next_ext[B_I1F] = next_ext[B_I1F] | ext_edge[1];
         next_ext[B_I2F] = next_ext[B_I2F] | ext_edge[2];
         reg_ext <= next_ext;
         if (wr_en && is_ofs(paddr, OFS_EDGE)) begin
            reg_edge <= pwdata[7:0] & WM_EDGE;
         end
      end
   end

   // Peripheral flags; serial bits are live mirrors
   // Peripheral event flags
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_pflag <= RST_PFLAG;
      end else begin
         logic [7:0] next_pflag;
         logic [7:0] ev;
         ev = periph_event & WM_PFLAG;
         ev[B_CCP] = ev[B_CCP] & ~ccp1_pwm_mode;
         ev[B_PSP] = ev[B_PSP] & HAS_SLAVE_PORT;
         next_pflag = (wr_en && is_ofs(paddr, OFS_PFLAG)) ?
            (pwdata[7:0] & WM_PFLAG) : reg_pflag;
         next_pflag = next_pflag | ev;
         next_pflag[B_PSP] = next_pflag[B_PSP] & HAS_SLAVE_PORT;
         reg_pflag <= next_pflag;
      end
   end

   always_comb begin
      pflag_view = reg_pflag;
      pflag_view[B_RX] = rx_buffer_full;
      pflag_view[B_TX] = tx_buffer_empty;
   end

   // Plain configuration registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_pen <= RST_PEN;
         reg_pprio <= RST_PPRIO;
         reg_chg_en <= RST_CHG_EN;
         reg_pu_en <= RST_PU_EN;
         prio_on <= 1'b0;
      end else if (wr_en) begin
         if (is_ofs(paddr, OFS_PEN)) begin
            reg_pen <= pwdata[7:0];
         end
         if (is_ofs(paddr, OFS_PPRIO)) begin
            reg_pprio <= pwdata[7:0];
         end
         if (is_ofs(paddr, OFS_CHG_EN)) begin
            reg_chg_en <= pwdata[7:0] & WM_CHG;
         end
         if (is_ofs(paddr, OFS_PU_EN)) begin
            reg_pu_en <= pwdata[7:0];
         end
         if (is_ofs(paddr, OFS_CFG)) begin
            prio_on <= pwdata[0];
         end
      end
   end

   // Service tracking: entry marks the level, return clears one
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hi_active <= 1'b0;
         lo_active <= 1'b0;
      end else if (core_ack && irq_req) begin
         if (take_hi) begin
            hi_active <= 1'b1;
         end else begin
            lo_active <= 1'b1;
         end
      end else if (core_return_from_irq_instr) begin
         if (hi_active) begin
            hi_active <= 1'b0;
         end else begin
            lo_active <= 1'b0;
         end
      end
   end

   // Entry outputs one cycle after the acknowledge
   // Push return and load vector
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stack_push <= 1'b0;
         pc_load <= 1'b0;
         stack_push_addr <= 16'h0000;
         pc_load_addr <= 16'h0000;
      end else begin
         stack_push <= core_ack & irq_req;
         pc_load <= core_ack & irq_req;
         if (core_ack && irq_req) begin
            stack_push_addr <= core_return_pc;
            pc_load_addr <= (take_hi || !prio_on) ? VEC_HIGH : VEC_LOW;
         end
      end
   end

   // Pull-ups on input pins only, unless all are disabled
   // Pull-up gating
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pullup_on <= 8'h00;
      end else begin
         pullup_on <= reg_edge[B_PUDIS] ? 8'h00
            : (reg_pu_en & portb_is_input);
      end
   end

   // Read mux, sampled in the setup cycle
   always_comb begin
      rd_value = 8'h00;
      if (is_ofs(paddr, OFS_MAIN)) rd_value = reg_main;
      if (is_ofs(paddr, OFS_EDGE)) rd_value = reg_edge;
      if (is_ofs(paddr, OFS_EXT)) rd_value = reg_ext;
      if (is_ofs(paddr, OFS_PFLAG)) rd_value = pflag_view;
      if (is_ofs(paddr, OFS_PEN)) rd_value = reg_pen;
      if (is_ofs(paddr, OFS_PPRIO)) rd_value = reg_pprio;
      if (is_ofs(paddr, OFS_CHG_EN)) rd_value = reg_chg_en;
      if (is_ofs(paddr, OFS_PU_EN)) rd_value = reg_pu_en;
      if (is_ofs(paddr, OFS_CFG)) rd_value = {7'h00, prio_on};
      if (is_ofs(paddr, OFS_STAT)) begin
         rd_value = {5'h00, irq_req, lo_active, hi_active};
      end
   end

   // Read data register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h000000, rd_value};
      end
   end

   // Entry clears the level enable on the next edge
   entry_clear_a: assert property (@(posedge clk) disable iff (reset)
      core_ack && irq_req && (!prio_on || req_hi)
      |=> !reg_main[B_GIE])
      else $error("global enable not cleared on entry");

   // No request while the top enable is off
   gie_off_a: assert property (@(posedge clk) disable iff (reset)
      !reg_main[B_GIE] |-> !irq_req)
      else $error("request with global enable off");

   // Low request needs both enables and no high service
   low_gate_a: assert property (@(posedge clk) disable iff (reset)
      req_lo |-> prio_on && reg_main[B_PEIE] && !hi_active)
      else $error("low request while blocked");

   // Vector follows level one cycle after acknowledge
   vector_load_a: assert property (@(posedge clk) disable iff (reset)
      core_ack && irq_req |=> pc_load && stack_push
      && pc_load_addr == ((!$past(prio_on) || $past(req_hi))
      ? VEC_HIGH : VEC_LOW))
      else $error("wrong vector load");

   // Return in compat mode sets the top enable
   return_from_irq_instr_set_a: assert property (@(posedge clk) disable iff (reset)
      core_return_from_irq_instr && !core_ack && !prio_on |=> reg_main[B_GIE])
      else $error("return did not restore enable");

   // An agreed rising pin level sets its flag on the next edge
   pin_latency_a: assert property (@(posedge clk) disable iff (reset)
      lvl_ok && $rose(sync3[0]) && sync2[0] && !ext_lvl[0]
      && reg_edge[B_EDGE0] |=> reg_main[B_I0F])
      else $error("pin flag late");

   // Timer event always sets its flag
   flag_set_a: assert property (@(posedge clk) disable iff (reset)
      timer0_overflow |=> reg_main[B_T0F])
      else $error("timer flag lost");

   // Unimplemented bits stay zero
   unimpl_zero_a: assert property (@(posedge clk) disable iff (reset)
      reg_edge[3] == 1'b0 && reg_edge[1] == 1'b0
      && reg_ext[5] == 1'b0 && reg_ext[2] == 1'b0)
      else $error("unimplemented bit set");

   // Pull-ups follow disable bit
   pullup_off_a: assert property (@(posedge clk) disable iff (reset)
      reg_edge[B_PUDIS] |=> pullup_on == 8'h00)
      else $error("pull-up active while disabled");

   // Slave port flag absent on the small variant
   psp_absent_a: assert property (@(posedge clk) disable iff (reset)
      !HAS_SLAVE_PORT |-> !pflag_view[B_PSP])
      else $error("slave port flag set");
endmodule

// [testbench/pintc_core_model.sv]
// Core model: takes interrupt requests and executes the return
// Assumes irq_req is a level and entry pulses follow one cycle later
`timescale 1ns/1ps
module pintc_core_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic irq_req,
   input wire logic pc_load,
   input wire logic [15:0] pc_load_addr,
   input wire logic ack_en,
   input wire logic return_from_irq_instr_go,
   output logic core_ack,
   output logic core_return_from_irq_instr,
   output logic [15:0] core_return_pc,
   output logic [15:0] last_vec,
   output logic [7:0] entries
);
   logic wait_load; // Ack taken, vector load outstanding

   // Ack at an instruction boundary, one request at a time
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         core_ack <= 1'b0;
         wait_load <= 1'b0;
         core_return_from_irq_instr <= 1'b0;
         core_return_pc <= 16'h0100;
         last_vec <= 16'h0000;
         entries <= 8'h00;
      end else begin
         core_ack <= ack_en && irq_req && !core_ack && !wait_load;
         core_return_from_irq_instr <= return_from_irq_instr_go;
         // Program counter keeps moving so each push differs
         core_return_pc <= core_return_pc + 16'h0002;
         if (core_ack && irq_req) begin
            wait_load <= 1'b1;
         end
         if (pc_load) begin
            wait_load <= 1'b0;
            last_vec <= pc_load_addr;
            entries <= entries + 8'h01;
         end
      end
   end
endmodule

// [testbench/testbench.sv]
// Self-checking bench of the interrupt controller over APB
// Assumes the core model above and zero-wait APB answers
`timescale 1ns/1ps
module testbench;
   import pintc_pkg::*;
   logic clk = 1'b0, reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, irq_req, stack_push, pc_load;
   logic [2:0] ext_pin = 3'h0;
   logic [7:4] portb_pin = 4'h0;
   logic portb_read = 1'b0, timer0_overflow = 1'b0;
   logic [7:0] portb_is_input = 8'h00, periph_event = 8'h00, pullup_on;
   logic ccp1_pwm_mode = 1'b0, rx_buffer_full = 1'b0;
   logic tx_buffer_empty = 1'b0, core_ack, core_return_from_irq_instr;
   logic ack_en = 1'b0, return_from_irq_instr_go = 1'b0;
   logic [15:0] core_return_pc, stack_push_addr, pc_load_addr, last_vec;
   logic [7:0] entries, rd;
   logic er;
   int err_count = 0, n_checks = 0, cyc = 0, n;
   logic [15:0] pc_at_ack;
   int n_push = 0;

   // Return address offered at each accepted entry, and push count
   always @(posedge clk) begin
      if (core_ack && irq_req) begin
         pc_at_ack <= core_return_pc;
      end
      if (stack_push) begin
         n_push <= n_push + 1;
      end
   end

   // Clock of 25 MHz
   always #20 clk = ~clk;

   pintc_top dut_u (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_pin(ext_pin), .portb_pin(portb_pin), .portb_read(portb_read),
      .portb_is_input(portb_is_input), .pullup_on(pullup_on),
      .timer0_overflow(timer0_overflow), .periph_event(periph_event),
      .ccp1_pwm_mode(ccp1_pwm_mode), .rx_buffer_full(rx_buffer_full),
      .tx_buffer_empty(tx_buffer_empty), .core_ack(core_ack),
      .core_return_from_irq_instr(core_return_from_irq_instr), .core_return_pc(core_return_pc),
      .irq_req(irq_req), .stack_push(stack_push),
      .stack_push_addr(stack_push_addr), .pc_load(pc_load),
      .pc_load_addr(pc_load_addr));

   pintc_core_model core_u (.clk(clk), .reset(reset), .irq_req(irq_req),
      .pc_load(pc_load), .pc_load_addr(pc_load_addr), .ack_en(ack_en),
      .return_from_irq_instr_go(return_from_irq_instr_go), .core_ack(core_ack),
      .core_return_from_irq_instr(core_return_from_irq_instr), .core_return_pc(core_return_pc),
      .last_vec(last_vec), .entries(entries));

   // Verdict and end of run
   task automatic print_verdict;
      if (err_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         print_verdict();
      end
   end

   // Compare seen against expected
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks = n_checks + 1;
      if (s !== e) begin
         err_count = err_count + 1;
         $display("MISMATCH %s exp %0h seen %0h", nm, e, s);
      end
   endtask

   // One APB transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Read a register and compare its byte
   task automatic rc(input string nm, input logic [11:0] a,
                     input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(nm, {24'h0, rd}, {24'h0, e});
   endtask

   // Reset held 20 cycles
   task automatic do_reset;
      reset <= 1'b1;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
   endtask

   // Wait for a given number of entries, bounded
   task automatic wait_entry(input logic [7:0] k);
      n = 0;
      while (entries !== k && n < 30) begin
         @(posedge clk);
         n = n + 1;
      end
   endtask

   // Let a few cycles pass, then compare the request line
   task automatic irq_is(input logic e);
      repeat (6) @(posedge clk);
      #1 chk("irq_req", {31'h0, irq_req}, {31'h0, e});
   endtask

   // One-cycle pulse on the core return
   task automatic return_from_irq_instr;
      @(posedge clk) return_from_irq_instr_go <= 1'b1;
      @(posedge clk) return_from_irq_instr_go <= 1'b0;
   endtask

   int bits[6] = '{7, 6, 3, 2, 1, 0};

   initial begin
      do_reset();
      // Reset values, unimplemented bits, unmapped address
      rc("main", OFS_MAIN, 8'h00);
      rc("edge", OFS_EDGE, 8'hF5);
      rc("ext", OFS_EXT, 8'hC0);
      rc("pprio", OFS_PPRIO, 8'hFF);
      apb(1'b1, OFS_EDGE, 8'hFF);
      rc("edge_ff", OFS_EDGE, 8'hF5);
      apb(1'b1, OFS_EXT, 8'hE4);
      rc("ext_e4", OFS_EXT, 8'hC0);
      apb(1'b0, 12'h300, 8'h00);
      chk("slverr", {31'h0, er}, 32'h1);
      // Flag sets with every enable off, then software clears it
      @(posedge clk) timer0_overflow <= 1'b1;
      @(posedge clk) timer0_overflow <= 1'b0;
      irq_is(1'b0);
      rc("t0flag", OFS_MAIN, 8'h04);
      apb(1'b1, OFS_MAIN, 8'h00);
      rc("t0clr", OFS_MAIN, 8'h00);
      // Compatibility entry, vector and return
      ack_en <= 1'b1;
      @(posedge clk) timer0_overflow <= 1'b1;
      @(posedge clk) timer0_overflow <= 1'b0;
      apb(1'b1, OFS_MAIN, 8'hA4);
      wait_entry(8'h01);
      chk("vec_c", {16'h0, last_vec}, 32'h0008);
      chk("push_n", n_push, 32'h1);
      chk("push_pc", {16'h0, stack_push_addr}, {16'h0, pc_at_ack});
      rc("gie_clr", OFS_MAIN, 8'h24);
      // Software clears the flag before the return
      apb(1'b1, OFS_MAIN, 8'h20);
      return_from_irq_instr();
      rc("gie_set", OFS_MAIN, 8'hA0);
      // Peripheral source needs the peripheral enable
      apb(1'b1, OFS_PEN, 8'h40);
      @(posedge clk) periph_event <= 8'h40;
      @(posedge clk) periph_event <= 8'h00;
      ack_en <= 1'b0;
      apb(1'b1, OFS_MAIN, 8'h80);
      irq_is(1'b0);
      apb(1'b1, OFS_MAIN, 8'hC0);
      irq_is(1'b1);

      // Priority levels on: low needs both enables
      do_reset();
      ack_en <= 1'b1;
      apb(1'b1, OFS_CFG, 8'h01);
      apb(1'b1, OFS_EDGE, 8'hF1);
      apb(1'b1, OFS_MAIN, 8'h60);
      @(posedge clk) timer0_overflow <= 1'b1;
      @(posedge clk) timer0_overflow <= 1'b0;
      irq_is(1'b0);
      apb(1'b1, OFS_MAIN, 8'hE4);
      wait_entry(8'h01);
      chk("vec_l", {16'h0, last_vec}, 32'h0018);
      rc("giel_clr", OFS_MAIN, 8'hA4);
      // High pin request preempts the low service
      apb(1'b1, OFS_MAIN, 8'hB0);
      @(posedge clk) ext_pin[0] <= 1'b1;
      wait_entry(8'h02);
      chk("vec_h", {16'h0, last_vec}, 32'h0008);
      rc("gieh_clr", OFS_MAIN, 8'h32);
      rc("stat", OFS_STAT, 8'h03);
      // Low request held off while the high service runs
      apb(1'b1, OFS_MAIN, 8'hE0);
      @(posedge clk) timer0_overflow <= 1'b1;
      @(posedge clk) timer0_overflow <= 1'b0;
      irq_is(1'b0);
      chk("entries", {24'h0, entries}, 32'h2);
      return_from_irq_instr();
      wait_entry(8'h03);
      chk("vec_l2", {16'h0, last_vec}, 32'h0018);

      // Falling-edge pin: rising ignored, latency three to four
      do_reset();
      apb(1'b1, OFS_EDGE, 8'hD5);
      apb(1'b1, OFS_EXT, 8'hC8);
      apb(1'b1, OFS_MAIN, 8'h80);
      @(posedge clk) ext_pin[1] <= 1'b1;
      irq_is(1'b0);
      rc("ext_rise", OFS_EXT, 8'hC8);
      @(posedge clk) ext_pin[1] <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         #1 n = n + 1;
      end while (irq_req !== 1'b1 && n < 20);
      chk("lat_ok", {31'h0, n >= LAT_MIN && n <= LAT_MAX}, 32'h1);
      rc("ext_fall", OFS_EXT, 8'hC9);

      // Port change: mismatch re-sets until the port is read
      do_reset();
      ack_en <= 1'b0;
      @(posedge clk) portb_read <= 1'b1;
      @(posedge clk) portb_read <= 1'b0;
      apb(1'b1, OFS_CHG_EN, 8'h10);
      apb(1'b1, OFS_MAIN, 8'h88);
      @(posedge clk) portb_pin[4] <= 1'b1;
      irq_is(1'b1);
      apb(1'b1, OFS_MAIN, 8'h88);
      rc("chg_hold", OFS_MAIN, 8'h89);
      @(posedge clk) portb_read <= 1'b1;
      @(posedge clk) portb_read <= 1'b0;
      apb(1'b1, OFS_MAIN, 8'h88);
      rc("chg_clr", OFS_MAIN, 8'h88);
      @(posedge clk) portb_pin[5] <= 1'b1;
      irq_is(1'b0);

      // Pull-ups: off by default, then on for input pins only
      portb_is_input <= 8'h0F;
      apb(1'b1, OFS_PU_EN, 8'hFF);
      chk("pu_off", {24'h0, pullup_on}, 32'h0);
      apb(1'b1, OFS_EDGE, 8'h75);
      repeat (2) @(posedge clk);
      chk("pu_on", {24'h0, pullup_on}, 32'h0F);

      // Peripheral flags, serial mirrors, capture gate
      do_reset();
      foreach (bits[i]) begin
         @(posedge clk) periph_event <= 8'h01 << bits[i];
         @(posedge clk) periph_event <= 8'h00;
         rc("pflag", OFS_PFLAG, 8'h01 << bits[i]);
         apb(1'b1, OFS_PFLAG, 8'h00);
      end
      rx_buffer_full <= 1'b1;
      ccp1_pwm_mode <= 1'b1;
      apb(1'b1, OFS_PFLAG, 8'h00);
      @(posedge clk) periph_event <= 8'h04;
      @(posedge clk) periph_event <= 8'h00;
      rc("rx_ro", OFS_PFLAG, 8'h20);
      rx_buffer_full <= 1'b0;
      tx_buffer_empty <= 1'b1;
      rc("tx_live", OFS_PFLAG, 8'h10);
      print_verdict();
   end
endmodule
